// ### hw/rpw_power_wakeup.sv
// RTC power management register with regulator shutdown and wake pin control.
// Assumes wake pin and alarm come from outside this clock and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module rpw_power_wakeup (
  // Clock, reset, enable.
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic wb_err_out,
  // Wake pin, alarm and core regulator enable pin.
  input wire logic wake_pin_in,
  output logic wake_pin_out,
  output logic wake_pin_oe_out,
  input wire logic rtc_alarm_in,
  input wire logic core_regulator_enable_pin_in,
  // Supply controls, active high enables.
  output logic analog_regulator_en_out,
  output logic core_regulator_en_out,
  output logic usb_phy_regulator_en_out,
  output logic bandgap_en_out,
  output logic analog_por_en_out,
  output logic rtc_clock_output_enable_out
);
  import rpw_pkg::*;

  logic [4:0] pmgt_reg;
  logic [4:0] pmgt_next;
  // Pin, alarm and enable-pin inputs pass two flip-flops before any logic reads them.
  logic [1:0] wake_sync_reg;
  logic [1:0] alarm_sync_reg;
  logic [1:0] cren_sync_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdat_reg;

  // Either shutdown bit of a register image asks for every regulator to be off.
  function automatic logic shutdown_req(input logic [4:0] image);
    return image[RPW_REG_SD_BIT] | image[RPW_BG_SD_BIT];
  endfunction

  // A request is taken only while no answer is outstanding, so requests stay at least two cycles apart.
  wire req = wb_cyc_in & wb_stb_in & ~ack_reg & ~err_reg;
  // Only the one mapped word answers with ack; any other address answers with err.
  wire hit = (wb_adr_in[17:0] == RPW_PMGT_ADDR) && (wb_adr_in[31:18] == 14'h0000);
  wire wr_lo = req & hit & wb_we_in & wb_sel_in[0];
  wire wake_dir_out = pmgt_reg[RPW_WAKE_DIR_BIT];
  wire pin_wake = wake_sync_reg[1] & ~wake_dir_out;
  wire wake_evt = pin_wake | alarm_sync_reg[1];
  wire any_sd = shutdown_req(pmgt_reg);
  wire next_sd = shutdown_req(pmgt_next);
  wire [4:0] wr_val = (wb_dat_in[4:0] & RPW_PMGT_WMASK) | (pmgt_reg & ~RPW_PMGT_WMASK);
  wire [4:0] after_wr = wr_lo ? wr_val : pmgt_reg;
  wire [4:0] wake_clr = (5'h01 << RPW_REG_SD_BIT) | (5'h01 << RPW_BG_SD_BIT);

  // A wake event outranks a same-cycle write of the shutdown bits.
  assign pmgt_next = wake_evt ? (after_wr & ~wake_clr) : after_wr;

  // The register and the bus answer share one process; a low enable freezes both.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pmgt_reg <= RPW_PMGT_RESET;
      wake_sync_reg <= 2'h0;
      alarm_sync_reg <= 2'h0;
      cren_sync_reg <= 2'h0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else if (clk_en_in)
    begin
      pmgt_reg <= pmgt_next;
      wake_sync_reg <= {wake_sync_reg[0], wake_pin_in};
      alarm_sync_reg <= {alarm_sync_reg[0], rtc_alarm_in};
      cren_sync_reg <= {cren_sync_reg[0], core_regulator_enable_pin_in};
      ack_reg <= req & hit;
      err_reg <= req & ~hit;
      rdat_reg <= (req & hit & ~wb_we_in) ? {27'h0000000, pmgt_reg} : 32'h00000000;
    end
  end

  // Every supply output and the pin enable is registered from the next register value.
  logic wake_out_reg;
  logic wake_oe_reg;
  logic ana_reg;
  logic core_reg;
  logic usb_reg;
  logic bg_reg;
  logic por_reg;
  logic clko_reg;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wake_out_reg <= 1'b0;
      wake_oe_reg <= 1'b0;
      ana_reg <= 1'b0;
      core_reg <= 1'b0;
      usb_reg <= 1'b0;
      bg_reg <= 1'b0;
      por_reg <= 1'b0;
      clko_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // The pin is open drain: its data stays low and only the enable moves.
      wake_out_reg <= 1'b0;
      wake_oe_reg <= pmgt_next[RPW_WAKE_DIR_BIT] & ~pmgt_next[RPW_WAKE_OUT_BIT];
      ana_reg <= ~next_sd;
      core_reg <= ~next_sd & cren_sync_reg[1];
      usb_reg <= ~next_sd;
      bg_reg <= ~pmgt_next[RPW_BG_SD_BIT];
      por_reg <= ~next_sd;
      clko_reg <= pmgt_next[RPW_CLKOUT_BIT];
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_err_out = err_reg;
  assign wb_dat_out = rdat_reg;
  assign wake_pin_out = wake_out_reg;
  assign wake_pin_oe_out = wake_oe_reg;
  assign analog_regulator_en_out = ana_reg;
  assign core_regulator_en_out = core_reg;
  assign usb_phy_regulator_en_out = usb_reg;
  assign bandgap_en_out = bg_reg;
  assign analog_por_en_out = por_reg;
  assign rtc_clock_output_enable_out = clko_reg;

  // Checks on what the block drives; each guards the rule tagged on its label line.
  // Checks that test $past(rst_n_in) skip the first edge after reset, while outputs still show reset.
  // A low clock enable holds all state, so most checks look only after an enabled edge.
  a_regs_off_together: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    any_sd |-> !analog_regulator_en_out && !core_regulator_en_out && !usb_phy_regulator_en_out)
    else $error("regulators not off together");

  a_usb_on_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && !any_sd |-> usb_phy_regulator_en_out)
    else $error("usb regulator off without shutdown");

  a_analog_on_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && !any_sd |-> analog_regulator_en_out)
    else $error("analog regulator off without shutdown");

  a_core_pin_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && !$past(cren_sync_reg[1]) |-> !core_reg)
    else $error("core regulator on while pin disables it");

  a_core_on_allowed: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && $past(cren_sync_reg[1])
    && !any_sd |-> core_regulator_en_out)
    else $error("core regulator off while pin and register allow it");

  a_wake_clears_sd: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(wake_evt) |-> !any_sd)
    else $error("wake event left shutdown set");

  a_reg_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(rst_n_in) && !$past(wr_lo) && !$past(wake_evt) |-> $stable(pmgt_reg))
    else $error("register changed without write or wake");

  a_pin_wake_input: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(wake_sync_reg[1]) && !$past(wake_dir_out) |-> !any_sd)
    else $error("pin high as input did not wake");

  a_no_wake_as_output: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(any_sd) && $past(wake_dir_out) && !$past(alarm_sync_reg[1])
    && !($past(wr_lo)) |-> any_sd)
    else $error("pin woke device while configured as output");

  a_drive_low_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wake_pin_oe_out |-> !wake_pin_out)
    else $error("wake pin driven high");

  a_release_on_one: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(pmgt_next[RPW_WAKE_OUT_BIT]) |-> !wake_pin_oe_out)
    else $error("wake pin driven while value is one");

  a_drive_on_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && $past(pmgt_next[RPW_WAKE_DIR_BIT])
    && !$past(pmgt_next[RPW_WAKE_OUT_BIT]) |-> wake_pin_oe_out)
    else $error("wake pin not pulled low for value zero");

  a_input_released: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && !$past(pmgt_next[RPW_WAKE_DIR_BIT]) |-> !wake_pin_oe_out)
    else $error("wake pin driven while set as input");

  a_bandgap_kept: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && !$past(pmgt_next[RPW_BG_SD_BIT]) |-> bg_reg)
    else $error("bandgap off without bandgap shutdown");

  a_bandgap_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(rst_n_in) && $past(pmgt_next[RPW_BG_SD_BIT])
    |-> !bandgap_en_out && !analog_por_en_out)
    else $error("bandgap or reset monitor on during bandgap shutdown");

  a_por_with_sd: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    any_sd |-> !analog_por_en_out)
    else $error("reset monitor on during shutdown");

  a_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wb_ack_out |-> wb_dat_out[31:5] == 27'h0000000)
    else $error("reserved bits read nonzero");

  a_read_matches: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) && $past(req) && $past(hit) && !$past(wb_we_in)
    |-> wb_ack_out && wb_dat_out[4:0] == $past(pmgt_reg))
    else $error("read data does not show the register");

  a_clkout_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $past(clk_en_in) |-> rtc_clock_output_enable_out == $past(pmgt_next[RPW_CLKOUT_BIT]))
    else $error("clock output not following its bit");
endmodule
`default_nettype wire

// ### hw/rpw_pkg.sv
// Constants for the RTC power and wake control block.
// Assumes a classic Wishbone slave with 32-bit data on one 40 MHz clock.
// Functional notes
// - Either shutdown bit switches all three regulators off together.
// - After shutdown a wake pin, armed alarm, register write or supply cycle restarts them.
// - Analog regulator stays on unless the software shutdown turns it off.
// - Core regulator is off while its enable pin disables it, or on shutdown.
// - Wake output value 0 drives the pin low; 1 leaves it released.
// - Wake direction 0 makes the pin an input; 1 makes it an output.
// - As an output the pin is only pulled low; an external pull-up raises it.
// - The pin wakes the device only while direction selects input.
// - Bits 15 to 5 read zero and ignore writes.
// - Bit 0 gates the RTC clock output; 0 disables, 1 enables.
// - Regulator shutdown keeps bandgap on and stops POR; bandgap shutdown also stops bandgap.
package rpw_pkg;
  localparam logic [15:0] RPW_PMGT_OFFSET = 16'h1930;
  localparam logic [17:0] RPW_PMGT_ADDR = 18'h064c0;
  localparam int RPW_CLKOUT_BIT = 0;
  localparam int RPW_REG_SD_BIT = 1;
  localparam int RPW_BG_SD_BIT = 2;
  localparam int RPW_WAKE_DIR_BIT = 3;
  localparam int RPW_WAKE_OUT_BIT = 4;
  localparam logic [4:0] RPW_PMGT_RESET = 5'h10;
  localparam logic [4:0] RPW_PMGT_WMASK = 5'h1f;
endpackage

// ### dv/rpw_wake_source.sv
// Wake source model with a pull-up on the shared open-drain wake line.
// Assumes the device pulls low only while its output enable is high.
`timescale 1ns/100ps
`default_nettype none
module rpw_wake_source (
  // Device side.
  input wire logic oe_in,
  input wire logic drive_in,
  // Source control: a driven request level, or a released line.
  input wire logic req_in,
  input wire logic release_in,
  // Resolved line level.
  output logic level_out
);
  assign level_out = (oe_in && !drive_in) ? 1'b0 : (release_in ? 1'b1 : req_in);
endmodule
`default_nettype wire

// ### dv/rtc_power_wakeup_control_tb.sv
// Self-checking bench for the RTC power and wake control block.
// Assumes the wake source model resolves the open-drain wake line.
`timescale 1ns/100ps
`default_nettype none
module rtc_power_wakeup_control_tb;
  import rpw_pkg::*;
  localparam logic [31:0] A = 32'(RPW_PMGT_ADDR);
  logic clk, rst_n, ce, cyc, stb, we, alarm, cpin, req, rel, pin, pout, oe, ack, err, e;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel;
  wire [5:0] pwr;
  int bad_count, compares;
  rpw_power_wakeup dut (.clock_in(clk), .rst_n_in(rst_n), .clk_en_in(ce), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err), .wake_pin_in(pin),
    .wake_pin_out(pout), .wake_pin_oe_out(oe), .rtc_alarm_in(alarm),
    .core_regulator_enable_pin_in(cpin), .analog_regulator_en_out(pwr[5]),
    .core_regulator_en_out(pwr[4]), .usb_phy_regulator_en_out(pwr[3]),
    .bandgap_en_out(pwr[2]), .analog_por_en_out(pwr[1]), .rtc_clock_output_enable_out(pwr[0]));
  rpw_wake_source src (.oe_in(oe), .drive_in(pout), .req_in(req), .release_in(rel),
    .level_out(pin));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    e = err;
    chk(n, 1, "answer one cycle after request");
    {cyc, stb} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100us;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n, cyc, stb, we, adr, wdat, sel, alarm, req, rel} = '0;
    {cpin, ce} = 2'b11;
    repeat (2) @(posedge clk);
    chk(pwr, 0, "outputs in reset");
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(pwr, 6'h3e, "outputs after reset");
    bus(0, A, 0, 4'h1);
    chk(q, 32'h10, "reset value");
    bus(1, A, 32'hffffffff, 4'hf);
    req <= 1'b1;
    repeat (5) @(posedge clk);
    chk(pwr, 6'h01, "full shutdown");
    bus(0, A, 0, 4'h1);
    chk(q, 32'h1f, "no wake as output");
    $display("test shutdown done");
    {req, rel} <= 2'b01;
    bus(1, A, 32'h0a, 4'h1);
    bus(1, A, 32'h1a, 4'h0);
    repeat (5) @(posedge clk);
    chk({oe, pout, pin, pwr}, 9'h104, "pin pulled low");
    bus(0, A, 0, 4'h1);
    chk(q, 32'h0a, "sel ignored");
    rel <= 1'b0;
    bus(1, A, 32'h12, 4'h1);
    repeat (5) @(posedge clk);
    chk({oe, pwr}, 7'h04, "released input");
    req <= 1'b1;
    repeat (5) @(posedge clk);
    bus(0, A, 0, 4'h1);
    chk({q[7:0], pwr}, 14'h043e, "pin wake");
    $display("test wake pin done");
    req <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1, A, 32'h04, 4'h1);
    repeat (5) @(posedge clk);
    chk(pwr, 6'h00, "bandgap shutdown");
    {ce, alarm} <= 2'b01;
    repeat (5) @(posedge clk);
    chk(pwr, 6'h00, "frozen while disabled");
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    bus(0, A, 0, 4'h1);
    chk({q[7:0], pwr}, 14'h003e, "alarm wake");
    {alarm, cpin} <= 2'b00;
    repeat (5) @(posedge clk);
    chk(pwr, 6'h2e, "core pin off");
    bus(0, A + 32'h4, 0, 4'h1);
    chk(e, 1, "unmapped address");
    $display("test alarm and pins done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
